// file: rtl/mcp_pkg.sv
package mcp_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_PS      = 5000;
    // shortest reset pulse honoured, in ns
    localparam int RESET_MIN_NS       = 10000;
    localparam int RESET_MIN_CYC      = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // management interface start-up time after reset, in ns
    localparam int MGMT_INIT_NS       = 2000;
    localparam int MGMT_INIT_CYC      = (MGMT_INIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W              = 16;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic RST_NOT_READY    = 1'b1;
    localparam logic RST_HIGH_POWER   = 1'b0;
    localparam logic RST_INIT_SW      = 1'b1;
    localparam logic RST_SYNC_LEVEL   = 1'b1;

    // ************************************************************
    // sequencing
    // ************************************************************
    typedef enum logic [1:0] {
        MCP_ST_RESET,
        MCP_ST_INIT,
        MCP_ST_READY
    } mcp_state_t;

endpackage

// file: rtl/mcp_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mcp_sync_if;
    logic async_in;
    logic level_out;
    logic rise;
    logic fall;
    modport producer (input async_in, output level_out, output rise, output fall);
    modport consumer (output async_in, input level_out, input rise, input fall);
endinterface
`default_nettype wire

// file: rtl/mcp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module mcp_pin_sync
    import mcp_pkg::*;
(
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    mcp_sync_if.producer       sif
);
    import mcp_pkg::*;

    logic [2:0] stage_reg;
    logic       level_reg;
    logic       rise_reg;
    logic       fall_reg;

    // ************************************************************
    // three stages; change counted once stage 2 and 3 agree
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage_reg <= {3{RST_SYNC_LEVEL}};
        end else begin
            stage_reg <= {stage_reg[1:0], sif.async_in};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            level_reg <= RST_SYNC_LEVEL;
            rise_reg  <= 1'b0;
            fall_reg  <= 1'b0;
        end else begin
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
            if ((stage_reg[1] == stage_reg[2]) && (stage_reg[2] != level_reg)) begin
                level_reg <= stage_reg[2];
                rise_reg  <= stage_reg[2];
                fall_reg  <= ~stage_reg[2];
            end
        end
    end

    assign sif.level_out = level_reg;
    assign sif.rise      = rise_reg;
    assign sif.fall      = fall_reg;
endmodule
`default_nettype wire

// file: rtl/mcp_control.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - management port answers only while module select is held low
// - reset held low past minimum length resets all settings to defaults
// - reset completion clears not-ready flag and asserts interrupt
// - power-up signals reset completion the same way, no pulse needed
// - init-mode input pulled high; high is software, low hardware control
// - software mode stays low power until software enables high power
// - hardware mode may enter high power once management is initialised
// - module ties presence line to ground when inserted
// - open-drain interrupt driven low on fault or critical status
module mcp_control
    import mcp_pkg::*;
#(
    parameter int RESET_MIN_CYCLES = RESET_MIN_CYC,
    parameter int MGMT_INIT_CYCLES = MGMT_INIT_CYC
)(
    input  wire logic I_CORE_CLK,
    input  wire logic I_RSTN,
    input  wire logic I_MODULE_SELECT_N,
    input  wire logic I_MODULE_RESET_N,
    input  wire logic I_INIT_CONTROL_SELECT,
    input  wire logic I_INIT_PULLUP_EN,
    input  wire logic I_MGMT_REQ,
    input  wire logic I_SW_HIGH_POWER_EN,
    input  wire logic I_FAULT_EVENT,
    input  wire logic I_FLAGS_CLEAR,
    output logic      O_MGMT_ENABLE,
    output logic      O_NOT_READY,
    output logic      O_HIGH_POWER,
    output logic      O_INIT_SW_MODE,
    output logic      O_MODULE_PRESENT_N_OUT,
    output logic      O_MODULE_PRESENT_N_OE,
    output logic      O_INTERRUPT_N_OUT,
    output logic      O_INTERRUPT_N_OE,
    output logic      O_FLAG_RESET_DONE,
    output logic      O_FLAG_FAULT
);
    import mcp_pkg::*;

    logic [1:0]       rst_sync_reg;
    logic             rst_n;
    mcp_sync_if       sel_if ();
    mcp_sync_if       rstp_if ();
    mcp_sync_if       init_if ();
    mcp_state_t       state_reg;
    logic [CNT_W-1:0] low_cnt_reg;
    logic [CNT_W-1:0] init_cnt_reg;
    logic             pin_reset;
    logic             not_ready_reg;
    logic             high_power_reg;
    logic             init_sw_reg;
    logic             done_flag_reg;
    logic             fault_flag_reg;
    logic             mgmt_en_reg;

    // ************************************************************
    // reset release and pin synchronisers
    // ************************************************************
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // undriven init pin floats high through the internal pull-up
    assign sel_if.async_in  = I_MODULE_SELECT_N;
    assign rstp_if.async_in = I_MODULE_RESET_N;
    assign init_if.async_in = I_INIT_PULLUP_EN ? I_INIT_CONTROL_SELECT : 1'b1;

    mcp_pin_sync u_sel_sync  (.i_clk(I_CORE_CLK), .i_rst_n(rst_n), .sif(sel_if));
    mcp_pin_sync u_rst_sync  (.i_clk(I_CORE_CLK), .i_rst_n(rst_n), .sif(rstp_if));
    mcp_pin_sync u_init_sync (.i_clk(I_CORE_CLK), .i_rst_n(rst_n), .sif(init_if));

    // ************************************************************
    // reset pulse qualification
    // ************************************************************
    // short glitches on the reset pin are ignored; only a held low counts
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_reg <= '0;
        end else if (rstp_if.level_out) begin
            low_cnt_reg <= '0;
        end else if (low_cnt_reg < CNT_W'(RESET_MIN_CYCLES)) begin
            low_cnt_reg <= low_cnt_reg + CNT_W'(1);
        end
    end
    assign pin_reset = (low_cnt_reg == CNT_W'(RESET_MIN_CYCLES));

    // ************************************************************
    // sequencer
    // ************************************************************
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= MCP_ST_RESET;
            init_cnt_reg <= '0;
        end else if (pin_reset) begin
            state_reg    <= MCP_ST_RESET;
            init_cnt_reg <= '0;
        end else begin
            case (state_reg)
                MCP_ST_RESET: begin
                    if (rstp_if.level_out) begin
                        state_reg <= MCP_ST_INIT;
                    end
                end
                MCP_ST_INIT: begin
                    if (init_cnt_reg == CNT_W'(MGMT_INIT_CYCLES - 1)) begin
                        state_reg <= MCP_ST_READY;
                    end else begin
                        init_cnt_reg <= init_cnt_reg + CNT_W'(1);
                    end
                end
                MCP_ST_READY: begin
                    state_reg <= MCP_ST_READY;
                end
                default: begin
                    state_reg <= MCP_ST_RESET;
                end
            endcase
        end
    end

    // init mode tracks the pin until ready: the sync resets to the pull-up level,
    // so sampling only in reset would miss a low pin at power-up
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            init_sw_reg <= RST_INIT_SW;
        end else if (state_reg != MCP_ST_READY) begin
            init_sw_reg <= init_if.level_out;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            not_ready_reg <= RST_NOT_READY;
        end else if (state_reg != MCP_ST_READY) begin
            not_ready_reg <= RST_NOT_READY;
        end else begin
            not_ready_reg <= 1'b0;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            high_power_reg <= RST_HIGH_POWER;
        end else if (state_reg != MCP_ST_READY) begin
            high_power_reg <= RST_HIGH_POWER;
        end else if (init_sw_reg) begin
            high_power_reg <= I_SW_HIGH_POWER_EN;
        end else begin
            high_power_reg <= 1'b1;
        end
    end

    // ************************************************************
    // management gating
    // ************************************************************
    // gated only in reset, so a module still in init can already answer
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            mgmt_en_reg <= 1'b0;
        end else begin
            mgmt_en_reg <= I_MGMT_REQ & ~sel_if.level_out & (state_reg != MCP_ST_RESET);
        end
    end

    // ************************************************************
    // flags and interrupt
    // ************************************************************
    // set beats clear so an event in the clearing cycle survives
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            done_flag_reg <= 1'b0;
        end else if (state_reg == MCP_ST_RESET) begin
            done_flag_reg <= 1'b0;
        end else if ((state_reg == MCP_ST_INIT) && (init_cnt_reg == CNT_W'(MGMT_INIT_CYCLES - 1))) begin
            done_flag_reg <= 1'b1;
        end else if (I_FLAGS_CLEAR) begin
            done_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            fault_flag_reg <= 1'b0;
        end else if (state_reg == MCP_ST_RESET) begin
            fault_flag_reg <= 1'b0;
        end else if (I_FAULT_EVENT) begin
            fault_flag_reg <= 1'b1;
        end else if (I_FLAGS_CLEAR) begin
            fault_flag_reg <= 1'b0;
        end
    end

    assign O_MGMT_ENABLE          = mgmt_en_reg;
    assign O_NOT_READY            = not_ready_reg;
    assign O_HIGH_POWER           = high_power_reg;
    assign O_INIT_SW_MODE         = init_sw_reg;
    assign O_MODULE_PRESENT_N_OUT = 1'b0;
    assign O_MODULE_PRESENT_N_OE  = 1'b1;
    assign O_INTERRUPT_N_OUT      = 1'b0;
    assign O_INTERRUPT_N_OE       = done_flag_reg | fault_flag_reg;
    assign O_FLAG_RESET_DONE      = done_flag_reg;
    assign O_FLAG_FAULT           = fault_flag_reg;

    // ************************************************************
    // checks
    // ************************************************************
    property p_mgmt_gate;
        @(posedge I_CORE_CLK) disable iff (!rst_n)
        O_MGMT_ENABLE |-> $past(~sel_if.level_out && I_MGMT_REQ);
    endproperty
    a_mgmt_gate: assert property (p_mgmt_gate) else $error("mgmt enabled without select");

    property p_reset_held;
        @(posedge I_CORE_CLK) disable iff (!rst_n)
        pin_reset |=> (state_reg == MCP_ST_RESET) ##1 (O_NOT_READY && !O_HIGH_POWER);
    endproperty
    a_reset_held: assert property (p_reset_held) else $error("held reset not applied");

    property p_done_irq;
        @(posedge I_CORE_CLK) disable iff (!rst_n)
        $rose(done_flag_reg) |-> O_INTERRUPT_N_OE ##1 !O_NOT_READY;
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("completion not signalled");

    property p_powerup_done;
        @(posedge I_CORE_CLK) disable iff (!rst_n)
        $rose(state_reg == MCP_ST_INIT) |-> ##[1:1000] done_flag_reg;
    endproperty
    a_powerup_done: assert property (p_powerup_done) else $error("no completion after init");

    property p_sw_low_power;
        @(posedge I_CORE_CLK) disable iff (!rst_n)
        (init_sw_reg && !$past(I_SW_HIGH_POWER_EN)) |-> !O_HIGH_POWER;
    endproperty
    a_sw_low_power: assert property (p_sw_low_power) else $error("high power without enable");

    property p_hw_high_power;
        @(posedge I_CORE_CLK) disable iff (!rst_n)
        (!init_sw_reg && state_reg == MCP_ST_READY) |=> O_HIGH_POWER;
    endproperty
    a_hw_high_power: assert property (p_hw_high_power) else $error("hw mode stuck low power");

    property p_present;
        @(posedge I_CORE_CLK) disable iff (!rst_n)
        O_MODULE_PRESENT_N_OE && !O_MODULE_PRESENT_N_OUT;
    endproperty
    a_present: assert property (p_present) else $error("presence not driven low");

    property p_fault_irq;
        @(posedge I_CORE_CLK) disable iff (!rst_n)
        (I_FAULT_EVENT && state_reg != MCP_ST_RESET && !pin_reset) |=> O_INTERRUPT_N_OE;
    endproperty
    a_fault_irq: assert property (p_fault_irq) else $error("fault not reported");

    property p_release;
        @(posedge I_CORE_CLK) disable iff (!rst_n)
        (I_FLAGS_CLEAR && !I_FAULT_EVENT && state_reg == MCP_ST_READY) |=> !O_INTERRUPT_N_OE;
    endproperty
    a_release: assert property (p_release) else $error("interrupt held with no flag");

endmodule
`default_nettype wire

// file: sim/mcp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcp_host_model (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_access,
    input  wire logic i_reset_req,
    input  wire logic i_int_oe,
    input  wire logic i_int_out,
    input  wire logic i_prs_oe,
    input  wire logic i_prs_out,
    output logic      o_module_select_n,
    output logic      o_interrupt_n,
    output logic      o_module_present_n,
    output logic      o_status_ok
);
    // ************************************************************
    // board side of the pins
    // ************************************************************
    // a private select line per module keeps a shared bus to one target
    assign o_module_select_n = ~i_access;
    // board pull-ups: the device only ever pulls low
    assign o_interrupt_n = i_int_oe ? i_int_out : 1'b1;
    assign o_module_present_n = i_prs_oe ? i_prs_out : 1'b1;
    // status is distrusted from reset until the next interrupt, completion or fault
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_reset_req) begin
            o_status_ok <= 1'b0;
        end else if (!o_interrupt_n) begin
            o_status_ok <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: sim/mcp_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin #0.1; chk((g) === (e)); end
module mcp_control_tb;
    logic clk, rstn, acc, req, mrst_n, mode, pu_en, swhp, fault, fclr;
    logic sel_n, int_n, prs_n, st_ok;
    logic mgmt_en, not_rdy, hi_pwr, sw_mode, prs_out, prs_oe, int_out, int_oe, f_done, f_fault;
    int   error_cnt = 0;
    int   compares = 0;
    int   cycles = 0;

    mcp_control #(.RESET_MIN_CYCLES(8), .MGMT_INIT_CYCLES(4)) dut (
        .I_CORE_CLK(clk), .I_RSTN(rstn), .I_MODULE_SELECT_N(sel_n),
        .I_MODULE_RESET_N(mrst_n), .I_INIT_CONTROL_SELECT(mode),
        .I_INIT_PULLUP_EN(pu_en), .I_MGMT_REQ(req), .I_SW_HIGH_POWER_EN(swhp),
        .I_FAULT_EVENT(fault), .I_FLAGS_CLEAR(fclr), .O_MGMT_ENABLE(mgmt_en),
        .O_NOT_READY(not_rdy), .O_HIGH_POWER(hi_pwr), .O_INIT_SW_MODE(sw_mode),
        .O_MODULE_PRESENT_N_OUT(prs_out), .O_MODULE_PRESENT_N_OE(prs_oe),
        .O_INTERRUPT_N_OUT(int_out), .O_INTERRUPT_N_OE(int_oe),
        .O_FLAG_RESET_DONE(f_done), .O_FLAG_FAULT(f_fault));

    mcp_host_model host (
        .i_clk(clk), .i_rst_n(rstn), .i_access(acc), .i_reset_req(~mrst_n),
        .i_int_oe(int_oe), .i_int_out(int_out), .i_prs_oe(prs_oe),
        .i_prs_out(prs_out), .o_module_select_n(sel_n), .o_interrupt_n(int_n),
        .o_module_present_n(prs_n), .o_status_ok(st_ok));

    // ************************************************************
    // clock, watchdog and bench tasks
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            error_cnt++;
            $display("Error %0t: run did not finish", $time);
            results();
        end
    end

    task chk(input bit ok);
        compares++;
        if (!ok) begin
            error_cnt++;
            $display("Error %0t: value mismatch", $time);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // bounded wait, since sync and init lengths are only loosely fixed
    task wait_done;
        int n;
        for (n = 0; n < 100 && f_done !== 1'b1; n++) begin
            @(posedge clk);
            #0.1;
        end
        if (n == 100) begin
            error_cnt++;
            $display("Error %0t: no reset completion", $time);
        end
    endtask

    task clear_flags;
        @(posedge clk) fclr <= 1'b1;
        @(posedge clk) fclr <= 1'b0;
        cyc(2);
    endtask

    task pulse_fault;
        @(posedge clk) fault <= 1'b1;
        @(posedge clk) fault <= 1'b0;
        cyc(2);
    endtask

    task results;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        // init pin undriven: the internal pull-up must read as software control
        rstn = 1'b0;
        acc = 1'b1;
        req = 1'b1;
        mrst_n = 1'b1;
        mode = 1'b0;
        pu_en = 1'b0;
        swhp = 1'b0;
        fault = 1'b0;
        fclr = 1'b0;
        cyc(2);
        `CHK(not_rdy, 1'b1)
        `CHK(hi_pwr, 1'b0)
        `CHK(prs_n, 1'b0)
        cyc(14);
        rstn <= 1'b1;
        wait_done();
        `CHK(int_n, 1'b0)
        `CHK(not_rdy, 1'b1)
        cyc(2);
        `CHK(not_rdy, 1'b0)
        `CHK(st_ok, 1'b1)
        `CHK(sw_mode, 1'b1)
        `CHK(hi_pwr, 1'b0)
        cyc(1);
        swhp <= 1'b1;
        cyc(4);
        `CHK(hi_pwr, 1'b1)
        `CHK(mgmt_en, 1'b1)
        cyc(1);
        acc <= 1'b0;
        cyc(8);
        `CHK(mgmt_en, 1'b0)
        cyc(1);
        acc <= 1'b1;
        cyc(8);
        `CHK(mgmt_en, 1'b1)
        cyc(1);
        req <= 1'b0;
        cyc(2);
        `CHK(mgmt_en, 1'b0)
        cyc(1);
        req <= 1'b1;
        clear_flags();
        `CHK(int_n, 1'b1)
        pulse_fault();
        `CHK(f_fault, 1'b1)
        `CHK(int_n, 1'b0)
        clear_flags();
        `CHK(int_n, 1'b1)
        // fault and clear in one cycle: the fault must survive
        @(posedge clk);
        fault <= 1'b1;
        fclr <= 1'b1;
        @(posedge clk);
        fault <= 1'b0;
        fclr <= 1'b0;
        cyc(2);
        `CHK(f_fault, 1'b1)
        `CHK(int_n, 1'b0)
        clear_flags();
        `CHK(int_n, 1'b1)
        // pulse shorter than the minimum must not reset
        cyc(1);
        mrst_n <= 1'b0;
        cyc(4);
        mrst_n <= 1'b1;
        cyc(12);
        `CHK(not_rdy, 1'b0)
        `CHK(hi_pwr, 1'b1)
        pulse_fault();
        mrst_n <= 1'b0;
        cyc(20);
        `CHK(not_rdy, 1'b1)
        `CHK(hi_pwr, 1'b0)
        `CHK(f_fault, 1'b0)
        `CHK(mgmt_en, 1'b0)
        `CHK(st_ok, 1'b0)
        cyc(1);
        mrst_n <= 1'b1;
        wait_done();
        `CHK(int_n, 1'b0)
        cyc(2);
        `CHK(not_rdy, 1'b0)
        `CHK(st_ok, 1'b1)
        clear_flags();
        // mode is re-sampled only before ready, here across a power-up reset on rstn
        rstn <= 1'b0;
        pu_en <= 1'b1;
        swhp <= 1'b0;
        cyc(16);
        rstn <= 1'b1;
        wait_done();
        cyc(4);
        `CHK(sw_mode, 1'b0)
        `CHK(hi_pwr, 1'b1)
        results();
    end
endmodule
`default_nettype wire
